// File: src/modem_irq_ctrl.sv
`timescale 1ns/1ps
// Modem control, modem status and interrupt logic of one serial channel.
module modem_irq_ctrl #(
    parameter int FILL_W = 7
) (
    input  wire logic              mclk_in,
    input  wire logic              arst_n_in,
    // Host register port, synchronous strobes from the bus front end.
    input  wire logic [2:0]        addr_in,
    input  wire logic              wr_stb_in,
    input  wire logic              rd_stb_in,
    input  wire logic [7:0]        wr_data_in,
    output logic      [7:0]        rd_data_out,
    output logic                   rd_valid_out,
    // Modem pins, active low; the interrupt output and its enable are active high.
    input  wire logic              cts_n_in,
    input  wire logic              dsr_n_in,
    input  wire logic              ri_n_in,
    input  wire logic              cd_n_in,
    output logic                   dtr_n_out,
    output logic                   rts_n_out,
    output logic                   general_output_pin_n_out,
    output logic                   irq_out,
    output logic                   irq_oe_out,
    // Serial lines.
    input  wire logic              serial_rx_pin_in,
    output logic                   serial_tx_pin_out,
    input  wire logic              tx_serial_in,
    output logic                   rx_serial_out,
    // Joins to the neighbouring blocks.
    input  wire logic              enh_write_en_in,
    input  wire logic              auto_rts_en_in,
    input  wire logic [7:0]        flow_threshold_reg_in,
    input  wire logic [FILL_W-1:0] rx_fill_in,
    input  wire logic              fifo_en_in,
    input  wire logic              line_err_in,
    input  wire logic              rx_timeout_in,
    input  wire logic              rx_data_in,
    input  wire logic              tx_thresh_evt_in,
    input  wire logic              transmit_holding_wr_in,
    input  wire logic              xoff_det_in,
    output logic                   fifo_ready_en_out,
    output logic                   xon_any_en_out,
    output logic                   thresh_access_out,
    output logic                   sleep_en_out,
    output logic                   baud_clk_en_out
);
    import modem_irq_pkg::*;

    typedef struct packed {
        logic [7:0]        modem_control;
        logic [7:0]        interrupt_enable;
        logic [3:0]        delta;
        logic [3:0]        prev_stat;
        logic              prev_ri_src;
        logic              prev_cts_n;
        logic              prev_rts_n;
        logic              txh_pend;
        logic              xoff_pend;
        logic              flow_pend;
        logic              auto_rts_n;
        logic [1:0]        div_cnt;
        logic              baud_en;
        logic [7:0]        rd_data;
        logic              rd_valid;
        logic              dtr_n;
        logic              rts_n;
        logic              gp_n;
        logic              irq;
        logic              tx_pin;
        logic              rx_ser;
    } state_t;

    state_t     s_reg;
    state_t     s_next;
    logic [1:0] rst_pipe_reg;
    logic       rst_n;
    logic [4:0] pins_sync;
    logic       cts_n_s;
    logic       dsr_n_s;
    logic       ri_n_s;
    logic       cd_n_s;
    logic       rx_pin_s;

    localparam state_t STATE_RST = '{
        modem_control:    MODEM_CTRL_RST,
        interrupt_enable: INT_ENABLE_RST,
        delta:            '0,
        prev_stat:        '0,
        prev_ri_src:      1'b1,
        prev_cts_n:       1'b1,
        prev_rts_n:       1'b1,
        txh_pend:         1'b0,
        xoff_pend:        1'b0,
        flow_pend:        1'b0,
        auto_rts_n:       1'b0,
        div_cnt:          '0,
        baud_en:          1'b0,
        rd_data:          '0,
        rd_valid:         1'b0,
        dtr_n:            1'b1,
        rts_n:            1'b1,
        gp_n:             1'b1,
        irq:              1'b0,
        tx_pin:           1'b1,
        rx_ser:           1'b1
    };

    // Release the asynchronous reset through two flip-flops.
    always_ff @(posedge mclk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_pipe_reg <= 2'b00;
        end else begin
            rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_pipe_reg[1];

    // Modem and serial pins idle high, so the synchronisers reset high.
    pin_sync #(
        .WIDTH (5),
        .INIT  (5'h1f)
    ) u_pin_sync (
        .clk_in   (mclk_in),
        .rst_n_in (rst_n),
        .async_in ({serial_rx_pin_in, cd_n_in, ri_n_in, dsr_n_in, cts_n_in}),
        .sync_out (pins_sync)
    );
    assign {rx_pin_s, cd_n_s, ri_n_s, dsr_n_s, cts_n_s} = pins_sync;

    // Next-state logic for the whole channel.
    always_comb begin
        logic       loop;
        logic [3:0] stat;
        logic       ri_src;
        logic [3:0] chg;
        logic       wr_ctl;
        logic       wr_ien;
        logic       rd_sts;
        logic       rd_idn;
        logic [7:0] wmask;
        logic       src_line;
        logic       src_tmo;
        logic       src_rx;
        logic       src_tx;
        logic       src_modem;
        logic       src_xoff;
        logic       src_flow;
        logic [5:0] ident;
        logic [7:0] idb;
        logic [FILL_W-1:0] halt_lvl;
        logic [FILL_W-1:0] resume_lvl;
        logic       rts_n_cur;
        s_next = s_reg;
        loop = s_reg.modem_control[MC_LOOP];
        wr_ctl = wr_stb_in && (addr_in == OFS_MODEM_CTRL);
        wr_ien = wr_stb_in && (addr_in == OFS_INT_ENABLE);
        rd_sts = rd_stb_in && (addr_in == OFS_MODEM_STAT);
        rd_idn = rd_stb_in && (addr_in == OFS_INT_IDENT);

        // Status levels in order carrier, ring, set-ready, clear-to-send.
        if (loop) begin
            stat = {s_reg.modem_control[MC_OUT], s_reg.modem_control[MC_FRDY],
                    s_reg.modem_control[MC_DTR], s_reg.modem_control[MC_RTS]};
            ri_src = s_reg.modem_control[MC_FRDY];
        end else begin
            stat = {~cd_n_s, ~ri_n_s, ~dsr_n_s, ~cts_n_s};
            ri_src = ri_n_s;
        end
        chg = stat ^ s_reg.prev_stat;
        s_next.prev_stat = stat;
        s_next.prev_ri_src = ri_src;

        // Change flags: a new change in the read cycle survives the clear.
        if (rd_sts) begin
            s_next.delta = 4'h0;
        end
        s_next.delta[0] = s_next.delta[0] | chg[0];
        s_next.delta[1] = s_next.delta[1] | chg[1];
        s_next.delta[3] = s_next.delta[3] | chg[3];
        s_next.delta[2] = s_next.delta[2] | (ri_src & ~s_reg.prev_ri_src);

        // Register writes; the high bits are guarded by the enhanced enable.
        wmask = enh_write_en_in ? 8'hff : CTL_BASE_MASK;
        if (wr_ctl) begin
            s_next.modem_control = (wr_data_in & wmask)
                                 | (s_reg.modem_control & ~wmask);
        end
        wmask = enh_write_en_in ? 8'hff : IEN_BASE_MASK;
        if (wr_ien) begin
            s_next.interrupt_enable = (wr_data_in & wmask)
                                    | (s_reg.interrupt_enable & ~wmask);
        end

        // Auto request-to-send follows the receive fill between two levels.
        halt_lvl = FILL_W'(flow_threshold_reg_in[3:0]) << THRESH_SHIFT;
        resume_lvl = FILL_W'(flow_threshold_reg_in[7:4]) << THRESH_SHIFT;
        if (rx_fill_in >= halt_lvl) begin
            s_next.auto_rts_n = 1'b1;
        end else if (rx_fill_in <= resume_lvl) begin
            s_next.auto_rts_n = 1'b0;
        end
        rts_n_cur = auto_rts_en_in ? s_reg.auto_rts_n
                                   : ~s_reg.modem_control[MC_RTS];
        s_next.rts_n = rts_n_cur;
        s_next.dtr_n = ~s_reg.modem_control[MC_DTR];
        s_next.gp_n = ~s_reg.modem_control[MC_OUT];

        // Source terms, each gated by its enable bit except the flow term, which is gated where its flag is set.
        src_line = line_err_in & s_reg.interrupt_enable[IE_LINE];
        src_tmo = rx_timeout_in & s_reg.interrupt_enable[IE_RX];
        src_rx = rx_data_in & s_reg.interrupt_enable[IE_RX];
        src_tx = s_reg.txh_pend & s_reg.interrupt_enable[IE_TX];
        src_modem = (|s_reg.delta) & s_reg.interrupt_enable[IE_MODEM];
        src_xoff = s_reg.xoff_pend & s_reg.interrupt_enable[IE_XOFF];
        src_flow = s_reg.flow_pend;

        // Priority encode of the pending source.
        if (src_line) begin
            ident = ID_LINE;
        end else if (src_tmo) begin
            ident = ID_TMO;
        end else if (src_rx) begin
            ident = ID_RX;
        end else if (src_tx) begin
            ident = ID_TX;
        end else if (src_modem) begin
            ident = ID_MODEM;
        end else if (src_xoff) begin
            ident = ID_XOFF;
        end else if (src_flow) begin
            ident = ID_FLOW;
        end else begin
            ident = ID_NONE;
        end
        idb = {fifo_en_in, fifo_en_in, ident};

        // Transmit flag is only raised while enabled, so re-enabling is silent.
        if ((rd_idn && ident == ID_TX) || transmit_holding_wr_in) begin
            s_next.txh_pend = 1'b0;
        end
        if (tx_thresh_evt_in && s_reg.interrupt_enable[IE_TX]) begin
            s_next.txh_pend = 1'b1;
        end
        if (rd_idn && ident == ID_XOFF) begin
            s_next.xoff_pend = 1'b0;
        end
        if (xoff_det_in) begin
            s_next.xoff_pend = 1'b1;
        end
        if (rd_idn && ident == ID_FLOW) begin
            s_next.flow_pend = 1'b0;
        end
        s_next.prev_cts_n = cts_n_s;
        s_next.prev_rts_n = rts_n_cur;
        if ((cts_n_s & ~s_reg.prev_cts_n & s_reg.interrupt_enable[IE_CTS])
            || (rts_n_cur & ~s_reg.prev_rts_n & s_reg.interrupt_enable[IE_RTS])) begin
            s_next.flow_pend = 1'b1;
        end
        s_next.irq = (ident != ID_NONE);

        // Loopback keeps the line marking and feeds transmit to receive.
        s_next.tx_pin = loop ? 1'b1 : tx_serial_in;
        s_next.rx_ser = loop ? tx_serial_in : rx_pin_s;

        // Prescaler: a baud enable every cycle, or every fourth one.
        if (s_reg.modem_control[MC_DIV4]) begin
            s_next.div_cnt = s_reg.div_cnt + 2'h1;
            s_next.baud_en = (s_reg.div_cnt == DIV4_LAST);
        end else begin
            s_next.div_cnt = 2'h0;
            s_next.baud_en = 1'b1;
        end

        // Read data; unmapped addresses read as zero.
        s_next.rd_valid = rd_stb_in;
        if (rd_stb_in) begin
            if (addr_in == OFS_MODEM_CTRL) begin
                s_next.rd_data = s_reg.modem_control;
            end else if (addr_in == OFS_MODEM_STAT) begin
                s_next.rd_data = {stat, s_reg.delta};
            end else if (addr_in == OFS_INT_ENABLE) begin
                s_next.rd_data = s_reg.interrupt_enable;
            end else if (addr_in == OFS_INT_IDENT) begin
                s_next.rd_data = idb;
            end else begin
                s_next.rd_data = 8'h00;
            end
        end
    end

    // All channel state moves on one edge.
    always_ff @(posedge mclk_in or negedge rst_n) begin
        if (!rst_n) begin
            s_reg <= STATE_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs come straight from the state flops.
    assign rd_data_out = s_reg.rd_data;
    assign rd_valid_out = s_reg.rd_valid;
    assign dtr_n_out = s_reg.dtr_n;
    assign rts_n_out = s_reg.rts_n;
    assign general_output_pin_n_out = s_reg.gp_n;
    assign irq_out = s_reg.irq;
    assign irq_oe_out = s_reg.modem_control[MC_OUT];
    assign serial_tx_pin_out = s_reg.tx_pin;
    assign rx_serial_out = s_reg.rx_ser;
    assign fifo_ready_en_out = s_reg.modem_control[MC_FRDY];
    assign xon_any_en_out = s_reg.modem_control[MC_XANY];
    assign thresh_access_out = s_reg.modem_control[MC_TACC];
    assign sleep_en_out = s_reg.interrupt_enable[IE_SLEEP];
    assign baud_clk_en_out = s_reg.baud_en;
endmodule

// File: src/modem_irq_pkg.sv
// Operation
// - Control bit 0 drives terminal-ready low when set; loopback feeds status bit 5.
// - Control bit 1 drives request-to-send low when set unless auto flow; loopback bit 4.
// - Control bit 2 enables the FIFO ready register; loopback feeds status bit 6.
// - Control bit 3 enables interrupt drive and pulls general output low; loopback bit 7.
// - Control bit 4 selects loopback: control bits feed status, transmit feeds receive.
// - Control bit 5 turns resume-on-any-character on.
// - Control bit 6 opens access to threshold and trigger registers.
// - Control bit 7 selects clock divide by four instead of by one.
// - Writes to control bits 7 to 5 need the enhanced write enable.
// - Status bits 0, 1, 3 set on clear-to-send, set-ready, carrier change; read clears.
// - Status bit 2 sets on ring source low to high; read clears.
// - Status bits 7 to 4 show inverted inputs, or control bits in loopback.
// - Enable bits 0 to 3 gate receive, transmit, line and modem interrupts.
// - Enable bit 4 is sleep; bits 5, 6, 7 enable Xoff, RTS and CTS interrupts.
// - Writes to enable bits 7 to 4 need the enhanced write enable.
// - Re-enabling the transmit interrupt raises nothing while below threshold.
// - Identification bit 0 reads zero when pending, one when idle.
// - Identification bits 7 and 6 both mirror the FIFO enable bit.
// - Identification bit 4 flags Xoff/special; bit 5 flags CTS/RTS low to high.
// - Identification bits 5 to 0 encode the highest priority pending source.
// - The interrupt output activates whenever an enabled source is pending.
// - Auto request-to-send goes high at halt level, low at resume level.
package modem_irq_pkg;
    // Register offsets on the 3-bit host address.
    localparam logic [2:0] OFS_INT_ENABLE = 3'h1;
    localparam logic [2:0] OFS_INT_IDENT  = 3'h2;
    localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
    localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
    // Reset values.
    localparam logic [7:0] MODEM_CTRL_RST = 8'h00;
    localparam logic [7:0] INT_ENABLE_RST = 8'h00;
    // Write masks: the low part is always writable, the high part needs the enable.
    localparam logic [7:0] CTL_BASE_MASK = 8'h1f;
    localparam logic [7:0] IEN_BASE_MASK = 8'h0f;
    // Modem control bit positions.
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_FRDY = 2;
    localparam int MC_OUT = 3;
    localparam int MC_LOOP = 4;
    localparam int MC_XANY = 5;
    localparam int MC_TACC = 6;
    localparam int MC_DIV4 = 7;
    // Interrupt enable bit positions.
    localparam int IE_RX = 0;
    localparam int IE_TX = 1;
    localparam int IE_LINE = 2;
    localparam int IE_MODEM = 3;
    localparam int IE_SLEEP = 4;
    localparam int IE_XOFF = 5;
    localparam int IE_RTS = 6;
    localparam int IE_CTS = 7;
    // Identification codes for bits 5..0.
    localparam logic [5:0] ID_LINE  = 6'h06;
    localparam logic [5:0] ID_TMO   = 6'h0c;
    localparam logic [5:0] ID_RX    = 6'h04;
    localparam logic [5:0] ID_TX    = 6'h02;
    localparam logic [5:0] ID_MODEM = 6'h00;
    localparam logic [5:0] ID_XOFF  = 6'h10;
    localparam logic [5:0] ID_FLOW  = 6'h20;
    localparam logic [5:0] ID_NONE  = 6'h01;
    // Prescaler divide-by-four count limit, and auto request-to-send threshold granularity shift.
    localparam logic [1:0] DIV4_LAST = 2'h3;
    localparam int THRESH_SHIFT = 2;
endpackage

// File: src/pin_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a group of asynchronous pins.
module pin_sync #(
    parameter int                WIDTH = 1,
    parameter logic [WIDTH-1:0]  INIT  = '0
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // The first stage is read only by the second stage.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= INIT;
            sync_out <= INIT;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule

// File: verif/modem_irq_monitor.sv
`timescale 1ns/1ps
// Concurrent checks on the pins and the register port of the modem and interrupt block.
module modem_irq_monitor #(
    parameter int FILL_W = 7
) (
    input wire logic              mclk_in,
    input wire logic              arst_n_in,
    input wire logic [2:0]        addr_in,
    input wire logic              wr_stb_in,
    input wire logic              rd_stb_in,
    input wire logic [7:0]        wr_data_in,
    input wire logic [7:0]        rd_data_out,
    input wire logic              cts_n_in,
    input wire logic              dsr_n_in,
    input wire logic              ri_n_in,
    input wire logic              cd_n_in,
    input wire logic              dtr_n_out,
    input wire logic              rts_n_out,
    input wire logic              general_output_pin_n_out,
    input wire logic              irq_out,
    input wire logic              enh_write_en_in,
    input wire logic              auto_rts_en_in,
    input wire logic [7:0]        flow_threshold_reg_in,
    input wire logic [FILL_W-1:0] rx_fill_in,
    input wire logic              fifo_en_in,
    input wire logic              xon_any_en_out,
    input wire logic              sleep_en_out
);
    import modem_irq_pkg::*;
    default clocking dc @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    // Decoded host accesses, shared by several properties.
    wire ctrl_wr = wr_stb_in && addr_in == OFS_MODEM_CTRL;
    wire ien_wr  = wr_stb_in && addr_in == OFS_INT_ENABLE;
    wire stat_rd = rd_stb_in && addr_in == OFS_MODEM_STAT;

    a_dtr_follow: assert property (ctrl_wr |-> ##2 dtr_n_out == !$past(wr_data_in[MC_DTR], 2))
        else $error("terminal ready pin does not follow the control write");
    a_rts_manual: assert property (ctrl_wr && !auto_rts_en_in ##1 !auto_rts_en_in [*2]
        |-> rts_n_out == !$past(wr_data_in[MC_RTS], 2))
        else $error("request pin does not follow the control write");
    a_out_follow: assert property (ctrl_wr
        |-> ##2 general_output_pin_n_out == !$past(wr_data_in[MC_OUT], 2))
        else $error("general output pin does not follow the control write");
    a_xon_guard: assert property (ctrl_wr |-> ##2 xon_any_en_out ==
        ($past(enh_write_en_in, 2) ? $past(wr_data_in[MC_XANY], 2) : $past(xon_any_en_out, 2)))
        else $error("resume-on-any flag wrong after control write");
    a_sleep_guard: assert property (ien_wr |-> ##2 sleep_en_out ==
        ($past(enh_write_en_in, 2) ? $past(wr_data_in[IE_SLEEP], 2) : $past(sleep_en_out, 2)))
        else $error("sleep enable wrong after enable write");
    a_ident_fifo: assert property (rd_stb_in && addr_in == OFS_INT_IDENT
        |=> rd_data_out[7:6] == {2{$past(fifo_en_in)}})
        else $error("identification top bits do not mirror fifo enable");
    a_delta_clear: assert property ($stable({cts_n_in, dsr_n_in, ri_n_in, cd_n_in}) [*6]
        ##0 stat_rd ##2 stat_rd |=> rd_data_out[3:0] == 4'h0)
        else $error("change flags not cleared by status read");
    a_rts_halt: assert property ((auto_rts_en_in
        && rx_fill_in >= FILL_W'({flow_threshold_reg_in[3:0], 2'b00})) [*2] |=> rts_n_out)
        else $error("automatic request pin not high at halt level");

    c_double_read: cover property ($stable({cts_n_in, dsr_n_in}) [*6] ##0 stat_rd ##2 stat_rd);
    c_irq_read: cover property (irq_out && rd_stb_in && addr_in == OFS_INT_IDENT);
    c_auto_halt: cover property (auto_rts_en_in && rts_n_out);
endmodule

// File: verif/modem_partner.sv
`timescale 1ns/1ps
// Data set on the far side: set-ready follows terminal-ready, clear-to-send follows the
// request after a prompt or a slow delay; ring and carrier come from the bench.
module modem_partner (
    input  wire logic clk_in,
    input  wire logic slow_in,
    input  wire logic ring_in,
    input  wire logic carrier_in,
    input  wire logic dtr_n_in,
    input  wire logic rts_n_in,
    output logic      cts_n_out,
    output logic      dsr_n_out,
    output logic      ri_n_out,
    output logic      cd_n_out
);
    int wait_cnt = 0;
    initial {cts_n_out, dsr_n_out, ri_n_out, cd_n_out} = 4'hf;
    // Pins move off the sampling edge, like any asynchronous modem line.
    always @(negedge clk_in) begin
        wait_cnt <= (cts_n_out != rts_n_in) ? wait_cnt + 1 : 0;
        if (wait_cnt >= (slow_in ? 5 : 1)) cts_n_out <= rts_n_in;
        dsr_n_out <= dtr_n_in;
        ri_n_out <= !ring_in;
        cd_n_out <= !carrier_in;
    end
endmodule

// File: verif/uart_modem_ctrl_irq_logic_bench.sv
`timescale 1ns/1ps
// Self-checking bench: register port, modem pins, loopback, interrupts and flow control.
module uart_modem_ctrl_irq_logic_bench;
    import modem_irq_pkg::*;
    logic       mclk_in = 1'b0, arst_n_in = 1'b0, wr_stb_in = 1'b0, rd_stb_in = 1'b0;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wr_data_in = 8'h00, flow_threshold_reg_in = 8'h24, rd_data_out, d, e;
    logic [6:0] rx_fill_in = 7'h00;
    logic [3:0] v, lv [5] = '{4'h5, 4'ha, 4'hf, 4'h6, 4'h0};
    logic       enh_write_en_in = 1'b0, auto_rts_en_in = 1'b0, fifo_en_in = 1'b0;
    logic       line_err_in = 1'b0, rx_timeout_in = 1'b0, rx_data_in = 1'b0, xoff_det_in = 1'b0;
    logic       tx_thresh_evt_in = 1'b0, transmit_holding_wr_in = 1'b0, serial_rx_pin_in = 1'b1;
    logic       tx_serial_in = 1'b1, slow = 1'b0, ring = 1'b0, carrier = 1'b0, ra = 1'b0;
    logic       cts_n_in, dsr_n_in, ri_n_in, cd_n_in, dtr_n_out, rts_n_out, irq_out, irq_oe_out;
    logic       general_output_pin_n_out, rd_valid_out, serial_tx_pin_out, rx_serial_out;
    logic       fifo_ready_en_out, xon_any_en_out, thresh_access_out, sleep_en_out;
    logic       baud_clk_en_out;
    logic [5:0] id;
    int         fails = 0, comparisons = 0, seed = 84, ctl = 0, ien = 0, pm, cnt, f;

    always #2.5 mclk_in = ~mclk_in;

    modem_irq_ctrl u_modem_irq_ctrl (.*);
    modem_partner u_modem_partner (.clk_in(mclk_in), .slow_in(slow), .ring_in(ring),
        .carrier_in(carrier), .dtr_n_in(dtr_n_out), .rts_n_in(rts_n_out), .cts_n_out(cts_n_in),
        .dsr_n_out(dsr_n_in), .ri_n_out(ri_n_in), .cd_n_out(cd_n_in));

    // One compare, counted, with a one-line report on mismatch.
    task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
        comparisons++;
        if (got_v !== exp_v) begin
            fails++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got_v, exp_v);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(negedge mclk_in);
    endtask
    // Strobes last one cycle and change only on the falling edge.
    task automatic wr(input logic [2:0] a, input logic [7:0] dv);
        @(negedge mclk_in);
        addr_in = a;
        wr_data_in = dv;
        wr_stb_in = 1'b1;
        @(negedge mclk_in);
        wr_stb_in = 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] ev, input logic [7:0] m = 8'hff);
        @(negedge mclk_in);
        addr_in = a;
        rd_stb_in = 1'b1;
        @(negedge mclk_in);
        rd_stb_in = 1'b0;
        chk({7'h00, rd_valid_out}, 8'h01);
        chk(rd_data_out & m, ev & m);
    endtask
    task automatic pulse(ref logic s);
        @(negedge mclk_in);
        s = 1'b1;
        @(negedge mclk_in);
        s = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("comparisons=%0d fails=%0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // The whole run is under a thousand cycles; this bound of 40000 cycles only catches a hang.
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end

    initial begin
        idle(3);
        arst_n_in = 1'b1;
        idle(8);
        rd(OFS_MODEM_CTRL, MODEM_CTRL_RST);
        rd(OFS_INT_ENABLE, INT_ENABLE_RST);
        rd(OFS_INT_IDENT, 8'h01);
        rd(3'h7, 8'h00);
        rd(OFS_MODEM_STAT, 8'h00, 8'h00);
        // Random control and enable writes, with and without the enhanced write enable.
        for (int i = 0; i < 12; i++) begin
            enh_write_en_in = i[0];
            slow = i[1];
            d = 8'($random(seed)) & 8'hef;
            e = 8'($random(seed));
            pm = ctl;
            ctl = enh_write_en_in ? d : (ctl & 8'he0) | (d & CTL_BASE_MASK);
            ien = enh_write_en_in ? e : (ien & 8'hf0) | (e & IEN_BASE_MASK);
            wr(OFS_MODEM_CTRL, d);
            wr(OFS_INT_ENABLE, e);
            idle(12);
            rd(OFS_MODEM_CTRL, 8'(ctl));
            rd(OFS_INT_ENABLE, 8'(ien));
            chk({dtr_n_out, rts_n_out, general_output_pin_n_out, irq_oe_out, fifo_ready_en_out,
                 xon_any_en_out, thresh_access_out, sleep_en_out}, {~ctl[0], ~ctl[1], ~ctl[3],
                 ctl[3], ctl[2], ctl[5], ctl[6], ien[4]});
            rd(OFS_MODEM_STAT, {2'b00, ctl[0], ctl[1], 2'b00, ctl[0] ^ pm[0],
                ctl[1] ^ pm[1]});
        end
        // Loopback: transmit held idle, transmit looped to receive, control bits to status.
        enh_write_en_in = 1'b1;
        tx_serial_in = 1'b0;
        serial_rx_pin_in = 1'b0;
        idle(5);
        chk({6'h00, serial_tx_pin_out, rx_serial_out}, 8'h00);
        wr(OFS_MODEM_CTRL, 8'h10);
        serial_rx_pin_in = 1'b1;
        idle(5);
        chk({6'h00, serial_tx_pin_out, rx_serial_out}, 8'h02);
        rd(OFS_MODEM_STAT, 8'h00, 8'hf0);
        pm = 0;
        for (int k = 0; k < 5; k++) begin
            v = lv[k];
            wr(OFS_MODEM_CTRL, {4'h1, v});
            idle(10);
            rd(OFS_MODEM_STAT, {v[3], v[2], v[0], v[1], v[3] ^ pm[3], v[2] & ~pm[2],
                v[0] ^ pm[0], v[1] ^ pm[1]});
            rd(OFS_MODEM_STAT, {v[3], v[2], v[0], v[1], 4'h0});
            pm = 32'(v);
        end
        wr(OFS_MODEM_CTRL, 8'h00);
        idle(12);
        rd(OFS_MODEM_STAT, 8'h00, 8'h00);
        rd(OFS_INT_IDENT, 8'h00, 8'h00);
        // Priority walk: transmit stays pending under every higher source.
        fifo_en_in = 1'b1;
        wr(OFS_INT_ENABLE, 8'h07);
        pulse(tx_thresh_evt_in);
        for (int i = 7; i >= 0; i--) begin
            {line_err_in, rx_timeout_in, rx_data_in} = 3'(i);
            idle(3);
            id = i[2] ? ID_LINE : i[1] ? ID_TMO : i[0] ? ID_RX : ID_TX;
            chk({7'h00, irq_out}, 8'h01);
            rd(OFS_INT_IDENT, {2'b11, id});
        end
        wr(OFS_INT_ENABLE, 8'h07);
        idle(3);
        chk({7'h00, irq_out}, 8'h00);
        rd(OFS_INT_IDENT, 8'hc1);
        pulse(tx_thresh_evt_in);
        pulse(transmit_holding_wr_in);
        rd(OFS_INT_IDENT, 8'hc1);
        wr(OFS_INT_ENABLE, 8'h00);
        line_err_in = 1'b1;
        idle(3);
        chk({7'h00, irq_out}, 8'h00);
        rd(OFS_INT_IDENT, 8'hc1);
        line_err_in = 1'b0;
        // Modem source: ring end and carrier arrival.
        wr(OFS_INT_ENABLE, 8'h08);
        ring = 1'b1;
        carrier = 1'b1;
        idle(8);
        ring = 1'b0;
        idle(8);
        rd(OFS_INT_IDENT, {2'b11, ID_MODEM});
        rd(OFS_MODEM_STAT, 8'h8c);
        rd(OFS_INT_IDENT, 8'hc1);
        wr(OFS_INT_ENABLE, 8'h20);
        pulse(xoff_det_in);
        idle(3);
        rd(OFS_INT_IDENT, {2'b11, ID_XOFF});
        rd(OFS_INT_IDENT, 8'hc1);
        wr(OFS_INT_ENABLE, 8'h80);
        wr(OFS_MODEM_CTRL, 8'h02);
        idle(12);
        wr(OFS_MODEM_CTRL, 8'h00);
        idle(12);
        rd(OFS_INT_IDENT, {2'b11, ID_FLOW});
        rd(OFS_INT_IDENT, 8'hc1);
        // Automatic request-to-send on random fill levels, halt 16 and resume 8.
        auto_rts_en_in = 1'b1;
        for (int i = 0; i < 24; i++) begin
            f = {$random(seed)} % 25;
            rx_fill_in = 7'(f);
            ra = (f >= 16) ? 1'b1 : (f <= 8) ? 1'b0 : ra;
            idle(3);
            chk({7'h00, rts_n_out}, {7'h00, ra});
        end
        auto_rts_en_in = 1'b0;
        // Prescaler: every cycle, then one enable in four.
        cnt = 0;
        repeat (40) begin
            @(negedge mclk_in);
            cnt += 32'(baud_clk_en_out);
        end
        chk(8'(cnt), 8'd40);
        wr(OFS_MODEM_CTRL, 8'h80);
        idle(4);
        cnt = 0;
        repeat (40) begin
            @(negedge mclk_in);
            cnt += 32'(baud_clk_en_out);
        end
        chk(8'(cnt), 8'd10);
        report_and_stop();
    end
endmodule

bind modem_irq_ctrl modem_irq_monitor #(.FILL_W(FILL_W)) u_modem_irq_monitor (.*);
